/* bench/ppp_port_props.sv */
`timescale 1ns/1ps

// ****************************************
// Port checker
// ****************************************
module ppp_port_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Programmer side
  input wire logic       hv_reset_detect,
  input wire logic       byte_half_select,
  input wire logic       oe_n,
  // Device side
  input wire logic       prog_data_bus_oe,
  input wire logic       ready_busy_n,
  input wire logic       prog_mode,
  input wire logic [3:0] fuse_state,
  input wire logic [1:0] lock_state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_clean_entry;
    (!hv_reset_detect && !byte_half_select)[*3]
      ##1 (hv_reset_detect && !byte_half_select)[*7];
  endsequence

  sequence s_spoiled_entry;
    (!hv_reset_detect)[*3] ##1 (hv_reset_detect && byte_half_select)[*3];
  endsequence

  a_reset_state: assert property (
    $rose(rstn) |-> ready_busy_n && !prog_mode && fuse_state == 4'h7)
    else $error("state after reset wrong");
  a_busy_min: assert property (
    $fell(ready_busy_n) |-> (!ready_busy_n)[*8])
    else $error("busy shorter than the bit time");
  a_busy_max: assert property (
    $fell(ready_busy_n) |-> ##[1:260] ready_busy_n)
    else $error("busy never ended");
  a_oe_release: assert property (
    oe_n[*5] |-> !prog_data_bus_oe)
    else $error("bus driven with output enable high");
  a_oe_cause: assert property (
    prog_data_bus_oe |-> !$past(oe_n, 3) || !$past(oe_n, 4))
    else $error("bus driven without output enable");
  a_mode_entry: assert property (
    s_clean_entry |-> prog_mode)
    else $error("clean entry refused");
  a_mode_refuse: assert property (
    s_spoiled_entry |-> ##1 (!prog_mode)[*8])
    else $error("spoiled entry accepted");
  a_mode_exit: assert property (
    (!hv_reset_detect)[*5] |-> !prog_mode)
    else $error("mode held without high voltage");
  a_fuse_quiet: assert property (
    !$stable(fuse_state) |-> !ready_busy_n)
    else $error("fuses changed outside a write");
  a_lock_quiet: assert property (
    |($past(lock_state) & ~lock_state) |-> !ready_busy_n)
    else $error("lock programmed outside a write");
endmodule

/* bench/ppp_port_tb.sv */
`timescale 1ns/1ps

// ****************************************
// Bench
// ****************************************
module ppp_port_tb;
  import ppp_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       hv = 1'b0;
  logic       xs = 1'b0;
  logic [1:0] act = ACT_IDLE;
  logic       bsel = 1'b0;
  logic       plat = 1'b0;
  logic       wr_n = 1'b1;
  logic       oe_n = 1'b1;
  logic       drv_en = 1'b0;
  logic [7:0] drv = 8'h00;
  logic [7:0] bus;
  logic [7:0] dout;
  logic       dout_en;
  logic       rdy;
  logic       mode;
  logic       tie;
  logic [3:0] fuse;
  logic [1:0] lock;
  logic [7:0] pick [3] = '{8'h00, 8'h05, 8'h7f};
  int         mismatches = 0;
  int         num_checks = 0;

  always #25 clk = ~clk;

  ppp_prog_model i_model (.clk(clk), .prog_en(drv_en), .prog_val(drv),
    .dev_en(dout_en), .dev_val(dout), .bus_level(bus), .upper_tie(tie));

  ppp_port #(.FLASH_PAGES(4), .EE_BYTES(16), .ERASE_CYCLES(600),
    .SIG0(8'h3c)) i_dut (
    .clk(clk), .rstn(rstn), .hv_reset_detect(hv), .load_strobe_clock(xs),
    .load_action_lsb(act[0]), .load_action_msb(act[1]),
    .byte_half_select(bsel), .byte_select_upper_tie(tie),
    .page_latch_strobe(plat), .wr_n(wr_n), .oe_n(oe_n),
    .prog_data_bus_in(bus), .prog_data_bus_out(dout),
    .prog_data_bus_oe(dout_en), .ready_busy_n(rdy), .prog_mode(mode),
    .fuse_state(fuse), .lock_state(lock));

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Pins held 4 cycles either side, synchronisers need 3
  task automatic load(input logic [1:0] a, input logic b,
                      input logic [7:0] d);
    act = a;
    bsel = b;
    drv = d;
    drv_en = 1'b1;
    cyc(4);
    xs = 1'b1;
    cyc(4);
    xs = 1'b0;
    cyc(4);
  endtask

  task automatic cmd(input logic [7:0] c);
    load(ACT_CMD, 1'b0, c);
  endtask

  task automatic setaddr(input logic [7:0] lo, input logic [7:0] hi);
    load(ACT_ADDR, 1'b0, lo);
    load(ACT_ADDR, 1'b1, hi);
  endtask

  task automatic latch(input logic b);
    bsel = b;
    cyc(4);
    plat = 1'b1;
    cyc(4);
    plat = 1'b0;
    cyc(4);
  endtask

  task automatic wpulse;
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    chk(8'(rdy), 8'h00);
    for (int i = 0; i < 1000 && rdy !== 1'b1; i++) cyc(1);
    if (rdy !== 1'b1) begin
      $display("wrong value at %0t: ready never returned", $time);
      mismatches++;
      end_of_test();
    end
  endtask

  // Erase gives no busy, so only elapsed time tells completion
  task automatic erase;
    cmd(8'h80);
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    chk(8'(rdy), 8'h01);
    cyc(700);
  endtask

  task automatic rd(input logic b, input logic [7:0] exp);
    drv_en = 1'b0;
    bsel = b;
    oe_n = 1'b0;
    cyc(6);
    chk(bus, exp);
    oe_n = 1'b1;
    cyc(6);
    chk(8'(dout_en), 8'h00);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cyc(16);
    rstn = 1'b1;
    cyc(4);
    chk(8'(rdy), 8'h01);
    chk({4'h0, fuse}, 8'h07);
    chk({6'h0, lock}, 8'h03);
    bsel = 1'b1;
    hv = 1'b1;
    cyc(12);
    chk(8'(mode), 8'h00);
    hv = 1'b0;
    bsel = 1'b0;
    cyc(8);
    hv = 1'b1;
    cyc(10);
    chk(8'(mode), 8'h01);
    erase();
    cmd(8'h02);
    setaddr(8'h80, 8'h01);
    rd(1'b0, 8'hff);
    rd(1'b1, 8'hff);
    cmd(8'h10);
    for (int i = 0; i < 128; i++) begin
      load(ACT_ADDR, 1'b0, 8'h80 | 8'(i));
      load(ACT_DATA, 1'b0, 8'(i));
      latch(1'b0);
      load(ACT_DATA, 1'b1, ~8'(i));
      latch(1'b1);
    end
    load(ACT_ADDR, 1'b1, 8'h01);
    wpulse();
    cmd(8'h00);
    cmd(8'h02);
    foreach (pick[k]) begin
      setaddr(8'h80 | pick[k], 8'h01);
      rd(1'b0, pick[k]);
      rd(1'b1, ~pick[k]);
    end
    cmd(8'h11);
    setaddr(8'h03, 8'h00);
    load(ACT_DATA, 1'b0, 8'ha5);
    wpulse();
    cmd(8'h03);
    rd(1'b0, 8'ha5);
    cmd(8'h40);
    load(ACT_DATA, 1'b0, 8'hd5);
    wpulse();
    chk({4'h0, fuse}, 8'h01);
    cmd(8'h04);
    rd(1'b0, 8'hd5);
    rd(1'b1, 8'hd7);
    cmd(8'h20);
    load(ACT_DATA, 1'b0, 8'hfd);
    wpulse();
    chk({6'h0, lock}, 8'h02);
    erase();
    chk({6'h0, lock}, 8'h03);
    chk({4'h0, fuse}, 8'h01);
    cmd(8'h03);
    rd(1'b0, 8'ha5);
    cmd(8'h02);
    rd(1'b0, 8'hff);
    cmd(8'h08);
    load(ACT_ADDR, 1'b0, 8'h00);
    rd(1'b0, 8'h3c);
    load(ACT_IDLE, 1'b0, 8'h02);
    rd(1'b0, 8'h3c);
    hv = 1'b0;
    cyc(8);
    chk(8'(mode), 8'h00);
    end_of_test();
  end
endmodule

bind ppp_port ppp_port_props i_props (.clk, .rstn, .hv_reset_detect,
  .byte_half_select, .oe_n, .prog_data_bus_oe, .ready_busy_n, .prog_mode,
  .fuse_state, .lock_state);

/* bench/ppp_prog_model.sv */
`timescale 1ns/1ps

// ****************************************
// Programmer-side bus model
// ****************************************
module ppp_prog_model (
  // Clock
  input  wire logic       clk,
  // Programmer drive
  input  wire logic       prog_en,
  input  wire logic [7:0] prog_val,
  // Device drive
  input  wire logic       dev_en,
  input  wire logic [7:0] dev_val,
  // Resolved bus and tie
  output logic      [7:0] bus_level,
  output logic            upper_tie
);
  logic [7:0] float_reg = 8'h5a;

  assign upper_tie = 1'b0;
  // Undriven bus wanders so a stale value never passes for data
  always_ff @(posedge clk) begin
    float_reg <= ~bus_level;
  end
  assign bus_level = dev_en ? dev_val : prog_en ? prog_val : float_reg;
endmodule

/* rtl/ppp_cfg.svh */
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH

// ****************************************
// Clock and timing
// ****************************************
`define PPP_CLK_NS        50
`define PPP_ENTRY_NS      100
`define PPP_ENTRY_CYC     ((`PPP_ENTRY_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_ERASE_NS      10000000
`define PPP_ERASE_CYC     (`PPP_ERASE_NS / `PPP_CLK_NS)
`define PPP_PAGE_PROG_CYC 64
`define PPP_EE_PROG_CYC   32
`define PPP_BIT_PROG_CYC  8

// ****************************************
// Memory geometry
// ****************************************
`define PPP_PAGE_WORDS    128
`define PPP_FLASH_PAGES   512
`define PPP_EE_BYTES      4096
`define PPP_FIFO_DEPTH    16

// ****************************************
// Load actions and command byte
// ****************************************
`define PPP_ACT_ADDR      2'h0
`define PPP_ACT_DATA      2'h1
`define PPP_ACT_CMD       2'h2
`define PPP_ACT_IDLE      2'h3
`define PPP_CMD_ERASE     7
`define PPP_CMD_FUSE      6
`define PPP_CMD_LOCK      5
`define PPP_CMD_WRITE     4
`define PPP_CMD_SIG       3
`define PPP_CMD_LFREAD    2
`define PPP_CMD_READ      1
`define PPP_CMD_EE        0
`define PPP_CMD_NOP       8'h00

// ****************************************
// Fuse and lock fields on the data bus
// ****************************************
`define PPP_D_SER_FUSE    5
`define PPP_D_KEEP_FUSE   3
`define PPP_D_LOCK_TWO    2
`define PPP_D_LOCK_ONE    1
`define PPP_D_START_HI    1
`define PPP_D_START_LO    0
`define PPP_FUSE_RST      4'h7
`define PPP_LOCK_RST      2'h3
`define PPP_LOCK_NONE     2'h3
`define PPP_LOCK_FULL     2'h0
`define PPP_BLANK_WORD    16'hffff
`define PPP_BLANK_BYTE    8'hff

`endif

/* rtl/ppp_pkg.sv */
package ppp_pkg;
  `include "ppp_cfg.svh"

  typedef enum logic [1:0] {
    ACT_ADDR = `PPP_ACT_ADDR,
    ACT_DATA = `PPP_ACT_DATA,
    ACT_CMD  = `PPP_ACT_CMD,
    ACT_IDLE = `PPP_ACT_IDLE
  } ppp_act_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_COPY  = 3'h1,
    ST_HOLD  = 3'h3,
    ST_ERASE = 3'h2
  } ppp_state_t;

  typedef struct packed {
    logic       hv;
    logic       tie;
    logic [1:0] act;
    logic       bsel;
    logic       oe_n;
    logic       wr_n;
    logic       plat;
    logic       load;
  } ppp_ctl_t;

  typedef struct packed {
    logic [6:0] idx;
    logic       hi;
    logic [7:0] data;
  } ppp_latch_t;
endpackage

/* rtl/ppp_port.sv */
`timescale 1ns/1ps

`include "ppp_cfg.svh"

// ****************************************
// Latch FIFO
// ****************************************
module ppp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  assign full      = (wp_reg[AW] != rp_reg[AW]) &&
                     (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign empty     = (wp_reg == rp_reg);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rp_reg[AW-1:0]];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_reg + (AW+1)'(push);
      rp_reg <= rp_reg + (AW+1)'(pop);
    end
  end
endmodule

// ****************************************
// Parallel programming port
// ****************************************
module ppp_port #(
  parameter int         FLASH_PAGES  = `PPP_FLASH_PAGES,
  parameter int         EE_BYTES     = `PPP_EE_BYTES,
  parameter int         ERASE_CYCLES = `PPP_ERASE_CYC,
  parameter int         PAGE_CYCLES  = `PPP_PAGE_PROG_CYC,
  parameter int         EE_CYCLES    = `PPP_EE_PROG_CYC,
  parameter int         BIT_CYCLES   = `PPP_BIT_PROG_CYC,
  parameter int         FIFO_DEPTH   = `PPP_FIFO_DEPTH,
  // Signature values are arbitrary
  parameter logic [7:0] SIG0         = 8'h5a,
  parameter logic [7:0] SIG1         = 8'h11,
  parameter logic [7:0] SIG2         = 8'h22
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Programmer controls
  input  wire logic       hv_reset_detect,
  input  wire logic       load_strobe_clock,
  input  wire logic       load_action_lsb,
  input  wire logic       load_action_msb,
  input  wire logic       byte_half_select,
  input  wire logic       byte_select_upper_tie,
  input  wire logic       page_latch_strobe,
  input  wire logic       wr_n,
  input  wire logic       oe_n,
  // Data bus
  input  wire logic [7:0] prog_data_bus_in,
  output logic      [7:0] prog_data_bus_out,
  output logic            prog_data_bus_oe,
  // Status
  output logic            ready_busy_n,
  output logic            prog_mode,
  output logic      [3:0] fuse_state,
  output logic      [1:0] lock_state
);
  import ppp_pkg::*;

  localparam int         FLASH_WORDS = FLASH_PAGES * `PPP_PAGE_WORDS;
  localparam int         FAW         = $clog2(FLASH_WORDS);
  localparam int         EAW         = $clog2(EE_BYTES);
  localparam int         CW          = $clog2(ERASE_CYCLES + 1);
  localparam logic [1:0] ENT_CYC     = 2'(`PPP_ENTRY_CYC);

  // ****************************************
  // Input synchronisers
  // ****************************************
  ppp_ctl_t   ctl_raw;
  ppp_ctl_t   ctl_s1;
  ppp_ctl_t   ctl_s2;
  ppp_ctl_t   ctl_s3;
  logic [7:0] dat_s1;
  logic [7:0] dat_s2;

  assign ctl_raw = '{hv: hv_reset_detect, tie: byte_select_upper_tie,
                     act: {load_action_msb, load_action_lsb},
                     bsel: byte_half_select, oe_n: oe_n, wr_n: wr_n,
                     plat: page_latch_strobe, load: load_strobe_clock};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_s1 <= '{oe_n: 1'b1, wr_n: 1'b1, act: 2'h3, default: 1'b0};
      ctl_s2 <= '{oe_n: 1'b1, wr_n: 1'b1, act: 2'h3, default: 1'b0};
      ctl_s3 <= '{oe_n: 1'b1, wr_n: 1'b1, act: 2'h3, default: 1'b0};
      dat_s1 <= 8'h00;
      dat_s2 <= 8'h00;
    end else begin
      ctl_s1 <= ctl_raw;
      ctl_s2 <= ctl_s1;
      ctl_s3 <= ctl_s2;
      dat_s1 <= prog_data_bus_in;
      dat_s2 <= dat_s1;
    end
  end

  // ****************************************
  // State
  // ****************************************
  ppp_state_t  state_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] lim_reg;
  logic [7:0]  cmd_reg;
  logic [15:0] addr_reg;
  logic [7:0]  data_reg;
  logic [3:0]  fuse_reg;
  logic [1:0]  lock_reg;
  logic        arm_reg;
  logic        busy_n_reg;
  logic        mode_reg;
  logic        ent_reg;
  logic [1:0]  quiet_reg;
  logic [1:0]  win_reg;
  logic        pend_reg;
  ppp_latch_t  latch_reg;
  logic [7:0]  dout_reg;
  logic        doe_reg;

  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0]  ee_mem    [EE_BYTES];
  logic [7:0]  pb_lo     [`PPP_PAGE_WORDS];
  logic [7:0]  pb_hi     [`PPP_PAGE_WORDS];

  // ****************************************
  // Decode
  // ****************************************
  ppp_act_t   act;
  ppp_latch_t fifo_out;
  logic load_rise;
  logic plat_rise;
  logic wr_fall;
  logic hv_rise;
  logic sel_busy;
  logic idle;
  logic erasing;
  logic loading;
  logic wr_go;
  logic c_erase;
  logic c_fuse;
  logic c_lock;
  logic c_write;
  logic c_ee;
  logic flash_lock;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic copy_last;
  logic hold_last;
  logic erase_last;
  logic fl_we;
  logic [FAW-1:0] fl_wa;
  logic [15:0] fl_wd;
  logic ee_we;
  logic [EAW-1:0] ee_wa;
  logic [7:0] ee_wd;
  logic [15:0] rd_word;
  logic [7:0] rd_flash;
  logic [7:0] rd_sig;
  logic [7:0] rd_lf;
  logic [7:0] rd_mux;
  logic [3:0] fuse_new;
  logic [6:0] cidx;

  assign act        = ppp_act_t'(ctl_s2.act);
  assign load_rise  = ctl_s2.load & ~ctl_s3.load;
  assign plat_rise  = ctl_s2.plat & ~ctl_s3.plat;
  assign wr_fall    = ~ctl_s2.wr_n & ctl_s3.wr_n;
  assign hv_rise    = ctl_s2.hv & ~ctl_s3.hv;
  assign sel_busy   = ctl_s2.bsel | ctl_s2.tie;
  assign idle       = (state_reg == ST_IDLE);
  assign erasing    = (state_reg == ST_ERASE);
  assign loading    = mode_reg & idle & load_rise;
  assign c_erase    = cmd_reg[`PPP_CMD_ERASE];
  assign c_fuse     = cmd_reg[`PPP_CMD_FUSE];
  assign c_lock     = cmd_reg[`PPP_CMD_LOCK];
  assign c_write    = cmd_reg[`PPP_CMD_WRITE];
  assign c_ee       = cmd_reg[`PPP_CMD_EE];
  // Lock one programmed blocks flash and EEPROM writes but not chip erase
  assign flash_lock = ~lock_reg[0];
  assign wr_go      = mode_reg & idle & busy_n_reg & wr_fall;
  assign cidx       = cnt_reg[6:0];
  assign copy_last  = (cidx == 7'h7f);
  assign hold_last  = (cnt_reg == lim_reg);
  assign erase_last = (int'(cnt_reg) == ERASE_CYCLES - 1);

  // Keep-EEPROM fuse cannot be programmed once any lock bit is
  assign fuse_new = {data_reg[`PPP_D_SER_FUSE],
                     (lock_reg != `PPP_LOCK_NONE) ? fuse_reg[2] :
                       data_reg[`PPP_D_KEEP_FUSE],
                     data_reg[`PPP_D_START_HI],
                     data_reg[`PPP_D_START_LO]};

  // ****************************************
  // Memory write ports
  // ****************************************
  assign fl_we = (state_reg == ST_COPY) |
                 (erasing & (int'(cnt_reg) < FLASH_WORDS));
  assign fl_wa = erasing ? FAW'(cnt_reg) :
                 FAW'({addr_reg[15:7], cidx});
  assign fl_wd = erasing ? `PPP_BLANK_WORD : {pb_hi[cidx], pb_lo[cidx]};
  assign ee_we = (erasing & fuse_reg[2] & (int'(cnt_reg) < EE_BYTES)) |
                 (wr_go & ~c_erase & ~c_fuse & ~c_lock & c_write & c_ee &
                  ~flash_lock);
  assign ee_wa = erasing ? EAW'(cnt_reg) : EAW'(addr_reg);
  assign ee_wd = erasing ? `PPP_BLANK_BYTE : data_reg;

  always_ff @(posedge clk) begin
    if (fl_we) begin
      flash_mem[fl_wa] <= fl_wd;
    end
  end

  always_ff @(posedge clk) begin
    if (ee_we) begin
      ee_mem[ee_wa] <= ee_wd;
    end
  end

  // ****************************************
  // Page buffer fill through FIFO
  // ****************************************
  // Drain stalls while a page is copied, so latches queue up
  assign fifo_out_ready = (state_reg != ST_COPY);

  ppp_fifo #(
    .W     ($bits(ppp_latch_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (pend_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (latch_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  always_ff @(posedge clk) begin
    if (fifo_out_valid & fifo_out_ready & fifo_out.hi) begin
      pb_hi[fifo_out.idx] <= fifo_out.data;
    end
    if (fifo_out_valid & fifo_out_ready & ~fifo_out.hi) begin
      pb_lo[fifo_out.idx] <= fifo_out.data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg  <= 1'b0;
      latch_reg <= '0;
    end else if (mode_reg & plat_rise) begin
      // A latch wins over a no-op in the same cycle
      pend_reg  <= 1'b1;
      latch_reg <= '{idx: addr_reg[6:0], hi: ctl_s2.bsel,
                     data: data_reg};
    end else if (loading & (act == ACT_CMD) &
                 (dat_s2 == `PPP_CMD_NOP)) begin
      pend_reg  <= 1'b0;
    end else if (fifo_in_ready) begin
      pend_reg  <= 1'b0;
    end
  end

  // ****************************************
  // Mode entry
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quiet_reg <= 2'h0;
      win_reg   <= 2'h0;
      ent_reg   <= 1'b0;
      mode_reg  <= 1'b0;
    end else begin
      quiet_reg <= sel_busy ? 2'h0 :
                   (quiet_reg == ENT_CYC) ? quiet_reg : quiet_reg + 2'h1;
      if (!ctl_s2.hv) begin
        ent_reg  <= 1'b0;
        mode_reg <= 1'b0;
      end else if (hv_rise) begin
        ent_reg  <= (quiet_reg == ENT_CYC) & ~sel_busy;
        win_reg  <= 2'h1;
      end else if (ent_reg & ~mode_reg) begin
        if (sel_busy) begin
          ent_reg <= 1'b0;
        end else if (win_reg == ENT_CYC) begin
          mode_reg <= 1'b1;
        end else begin
          win_reg <= win_reg + 2'h1;
        end
      end
    end
  end

  // ****************************************
  // Loads and sequencer
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_reg  <= `PPP_CMD_NOP;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
    end else if (loading) begin
      unique case (act)
        ACT_ADDR: if (ctl_s2.bsel) addr_reg[15:8] <= dat_s2;
                  else addr_reg[7:0] <= dat_s2;
        ACT_DATA: data_reg <= dat_s2;
        ACT_CMD:  cmd_reg <= dat_s2;
        ACT_IDLE: cmd_reg <= cmd_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= '0;
      lim_reg    <= '0;
      busy_n_reg <= 1'b1;
      arm_reg    <= 1'b0;
      fuse_reg   <= `PPP_FUSE_RST;
      lock_reg   <= `PPP_LOCK_RST;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
          if (loading & (act == ACT_CMD) & dat_s2[`PPP_CMD_ERASE]) begin
            state_reg <= ST_ERASE;
            arm_reg   <= 1'b0;
          end else if (wr_go & ~c_erase) begin
            busy_n_reg <= 1'b0;
            state_reg  <= ST_HOLD;
            lim_reg    <= CW'(BIT_CYCLES - 1);
            if (c_fuse) begin
              fuse_reg <= fuse_new;
            end else if (c_lock) begin
              lock_reg <= lock_reg & {data_reg[`PPP_D_LOCK_TWO],
                                      data_reg[`PPP_D_LOCK_ONE]};
            end else if (c_write & c_ee) begin
              lim_reg <= CW'(EE_CYCLES - 1);
            end else if (c_write & ~flash_lock) begin
              state_reg <= ST_COPY;
            end
          end
        end
        ST_COPY: begin
          cnt_reg <= cnt_reg + CW'(1);
          if (copy_last) begin
            state_reg <= ST_HOLD;
            cnt_reg   <= '0;
            lim_reg   <= CW'(PAGE_CYCLES - 1);
          end
        end
        ST_HOLD: begin
          cnt_reg <= cnt_reg + CW'(1);
          if (hold_last) begin
            state_reg  <= ST_IDLE;
            busy_n_reg <= 1'b1;
          end
        end
        ST_ERASE: begin
          // Ready/busy is left alone here
          cnt_reg <= cnt_reg + CW'(1);
          if (mode_reg & wr_fall) begin
            arm_reg <= 1'b1;
          end
          if (erase_last) begin
            state_reg <= ST_IDLE;
            arm_reg   <= 1'b0;
            if (arm_reg | (mode_reg & wr_fall)) begin
              lock_reg <= `PPP_LOCK_NONE;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  assign rd_word  = flash_mem[FAW'(addr_reg)];
  assign rd_flash = c_ee ? ee_mem[EAW'(addr_reg)] :
                    ctl_s2.bsel ? rd_word[15:8] : rd_word[7:0];
  assign rd_sig   = (addr_reg[7:0] == 8'h00) ? SIG0 :
                    (addr_reg[7:0] == 8'h01) ? SIG1 :
                    (addr_reg[7:0] == 8'h02) ? SIG2 : `PPP_BLANK_BYTE;
  assign rd_lf    = {2'h3, fuse_reg[3], 1'b1, fuse_reg[2], lock_reg[1],
                     ctl_s2.bsel ? lock_reg[0] : fuse_reg[1],
                     fuse_reg[0]};
  assign rd_mux   = cmd_reg[`PPP_CMD_SIG]    ? rd_sig :
                    cmd_reg[`PPP_CMD_LFREAD] ? rd_lf :
                    (lock_reg == `PPP_LOCK_FULL) ? `PPP_BLANK_BYTE :
                    rd_flash;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dout_reg <= 8'h00;
      doe_reg  <= 1'b0;
    end else begin
      dout_reg <= rd_mux;
      doe_reg  <= mode_reg & ~ctl_s2.oe_n &
                  (cmd_reg[`PPP_CMD_SIG] | cmd_reg[`PPP_CMD_LFREAD] |
                   cmd_reg[`PPP_CMD_READ]);
    end
  end

  assign prog_data_bus_out = dout_reg;
  assign prog_data_bus_oe  = doe_reg;
  assign ready_busy_n      = busy_n_reg;
  assign prog_mode         = mode_reg;
  assign fuse_state        = fuse_reg;
  assign lock_state        = lock_reg;
endmodule
